/* File: common/odc_pkg.sv */
// Constants for the output driver configuration register bank.
// Assumes a 10 MHz control clock and an 8-bit paged register port.
package odc_pkg;
  // Register offsets within a page
  localparam logic [7:0] OFF_PAGE = 8'h00;
  localparam logic [7:0] OFF_PWR = 8'h09;
  localparam logic [7:0] OFF_CM = 8'h0a;
  localparam logic [7:0] OFF_OCP = 8'h0b;
  localparam logic [7:0] OFF_ROUTE = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STS = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h21;
  localparam logic [7:0] OFF_IRQ_EN = 8'h22;
  localparam logic [7:0] BLOCK_PAGE = 8'h01;
  // Writable bits; the rest are reserved and read as zero
  localparam logic [7:0] MASK_PWR = 8'h3f;
  localparam logic [7:0] MASK_CM = 8'h7b;
  localparam logic [7:0] MASK_OCP = 8'h1f;
  localparam logic [7:0] MASK_ROUTE = 8'h0f;
  localparam logic [7:0] MASK_IRQ = 8'h03;
  // Reset values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_PWR = 8'h00;
  localparam logic [7:0] RST_CM = 8'h00;
  localparam logic [7:0] RST_OCP = 8'h10;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  // Power enable field positions
  localparam int PWR_HP_LEFT = 5;
  localparam int PWR_HP_RIGHT = 4;
  localparam int PWR_LINE_LEFT = 3;
  localparam int PWR_LINE_RIGHT = 2;
  localparam int PWR_MIX_LEFT = 1;
  localparam int PWR_MIX_RIGHT = 0;
  // Common mode and supply field positions
  localparam int CM_CHIP = 6;
  localparam int CM_HP_LO = 4;
  localparam int CM_LINE = 3;
  localparam int CM_SUPPLY = 1;
  localparam int CM_RANGE = 0;
  // Over-current field positions
  localparam int OCP_EN = 4;
  localparam int OCP_DEB_LO = 1;
  localparam int OCP_ACT = 0;
  // Headphone common mode levels as driven to the analog side
  typedef enum logic [1:0] {
    ODC_CM_CHIP = 2'b00,
    ODC_CM_1V25 = 2'b01,
    ODC_CM_1V5 = 2'b10,
    ODC_CM_1V65 = 2'b11
  } odc_hp_cm_t;
  // Debounce timing: one millisecond tick, shortest period 8 ms
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DEB_BASE_MS = 8;
  localparam int DEB_BASE_SHIFT = $clog2(DEB_BASE_MS) - 1;
endpackage

/* File: common/odc_ocp_if.sv */
// Carrier between the register bank and one over-current debouncer.
// Assumes both ends run on the same control clock.
`timescale 1ns/1ps
interface odc_ocp_if;
  logic det_en;
  logic [2:0] deb_code;
  logic hold;
  logic sense;
  logic trip;
  modport ctl (output det_en, output deb_code, output hold, output sense, input trip);
  modport det (input det_en, input deb_code, input hold, input sense, output trip);
endinterface

/* File: design/odc_ocp_debounce.sv */
// Over-current debouncer for one headphone driver.
// Assumes the sense input is synchronous to i_clock.
`timescale 1ns/1ps
module odc_ocp_debounce #(
  parameter int MS_CYCLES = odc_pkg::MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  odc_ocp_if.det oc
);
  localparam int PW = $clog2(MS_CYCLES + 1);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_TRIP = 2'b10
  } odc_deb_state_t;

  odc_deb_state_t state_r;
  logic [PW-1:0] pre_r;
  logic [9:0] ms_r;
  logic [9:0] target;
  logic tick;

  // Period in ms is 8 shifted left by code-1; a four-bit sum keeps 256 and 512 ms from wrapping
  assign target = 10'h001 << ({1'b0, oc.deb_code} + 4'(odc_pkg::DEB_BASE_SHIFT));
  assign tick = (pre_r == PW'(MS_CYCLES - 1));
  assign oc.trip = (state_r == ST_TRIP);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      pre_r <= '0;
      ms_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          pre_r <= '0;
          ms_r <= '0;
          if (oc.det_en && oc.sense) begin
            state_r <= (oc.deb_code == 3'h0) ? ST_TRIP : ST_COUNT;
          end
        end
        ST_COUNT: begin
          // Any gap in the condition restarts the whole period
          if (!oc.det_en || !oc.sense) begin
            state_r <= ST_IDLE;
            pre_r <= '0;
            ms_r <= '0;
          end else if (tick) begin
            pre_r <= '0;
            ms_r <= ms_r + 10'h001;
            if (ms_r == target - 10'h001) begin
              state_r <= ST_TRIP;
            end
          end else begin
            pre_r <= pre_r + PW'(1);
          end
        end
        ST_TRIP: begin
          // A powered-down driver stays off until software drops its enable
          if (!oc.det_en || (!oc.sense && !oc.hold)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  chk_detect_off: assert property (@(posedge i_clock) disable iff (i_rst)
    !oc.det_en |=> !oc.trip)
    else $error("Trip while detection disabled");
  chk_no_debounce: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_r == ST_IDLE && oc.det_en && oc.sense && oc.deb_code == 3'h0) |=> oc.trip)
    else $error("Undebounced trip late");
  chk_count_restart: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_r == ST_COUNT && !oc.sense) |=> (state_r == ST_IDLE && ms_r == 10'h000))
    else $error("Debounce did not restart");
  chk_early_trip: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_r == ST_COUNT && ms_r < target - 10'h001) |=> !oc.trip)
    else $error("Trip before debounce period");
endmodule // odc_ocp_debounce

/* File: design/odc_regs.sv */
// Output driver configuration registers: power, common mode, supply,
// over-current protection and left headphone routing.
// Assumes a single-cycle strobe register port on the control clock.
`timescale 1ns/1ps

module odc_regs #(
  parameter int MS_CYCLES = odc_pkg::MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_oc_left,
  input wire logic i_oc_right,
  output logic o_left_headphone_driver_pwr,
  output logic o_right_headphone_driver_pwr,
  output logic o_left_line_driver_pwr,
  output logic o_right_line_driver_pwr,
  output logic o_left_mixer_amp_pwr,
  output logic o_right_mixer_amp_pwr,
  output logic o_chip_cm_low,
  output logic [1:0] o_hp_cm,
  output logic o_line_cm_regulator,
  output logic o_hp_supply_regulator,
  output logic o_regulator_range_high,
  output logic [1:0] o_oc_limit,
  output logic o_route_dac_pos,
  output logic o_route_left_input_one,
  output logic o_route_left_mixer_amp,
  output logic o_route_right_mixer_amp,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off,
                               input logic paged);
    hit = (addr == off) && paged;
  endfunction

  logic [7:0] page_r;
  logic [7:0] pwr_r;
  logic [7:0] cm_r;
  logic [7:0] ocp_r;
  logic [7:0] route_r;
  logic [7:0] irq_sts_r;
  logic [7:0] irq_sts_nxt;
  logic [7:0] irq_en_r;
  logic [7:0] rdata_nxt;
  logic [1:0] trip;
  logic [1:0] trip_d_r;
  logic [1:0] sense;
  logic [1:0] drv_en;
  logic on_page;
  logic hp_cut;
  odc_pkg::odc_hp_cm_t hp_cm_nxt;

  // The page register is visible on every page; the rest only on ours
  assign on_page = (page_r == odc_pkg::BLOCK_PAGE);
  assign sense = {i_oc_right, i_oc_left};
  assign drv_en = {pwr_r[odc_pkg::PWR_HP_RIGHT], pwr_r[odc_pkg::PWR_HP_LEFT]};

  ////////////////////////////////////////////////////////////////////////////
  // Page select

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      page_r <= odc_pkg::RST_PAGE;
    end else if (i_wr && hit(i_addr, odc_pkg::OFF_PAGE, 1'b1)) begin
      page_r <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits are never stored

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pwr_r <= odc_pkg::RST_PWR;
    end else if (i_wr && hit(i_addr, odc_pkg::OFF_PWR, on_page)) begin
      pwr_r <= i_wdata & odc_pkg::MASK_PWR;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cm_r <= odc_pkg::RST_CM;
    end else if (i_wr && hit(i_addr, odc_pkg::OFF_CM, on_page)) begin
      cm_r <= i_wdata & odc_pkg::MASK_CM;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ocp_r <= odc_pkg::RST_OCP;
    end else if (i_wr && hit(i_addr, odc_pkg::OFF_OCP, on_page)) begin
      ocp_r <= i_wdata & odc_pkg::MASK_OCP;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      route_r <= odc_pkg::RST_ROUTE;
    end else if (i_wr && hit(i_addr, odc_pkg::OFF_ROUTE, on_page)) begin
      route_r <= i_wdata & odc_pkg::MASK_ROUTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Over-current debouncers, one per headphone driver

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ocp
      odc_ocp_if oc_if ();
      assign oc_if.det_en = ocp_r[odc_pkg::OCP_EN];
      assign oc_if.deb_code = ocp_r[odc_pkg::OCP_DEB_LO +: 3];
      assign oc_if.hold = ocp_r[odc_pkg::OCP_ACT] && drv_en[g];
      assign oc_if.sense = sense[g];
      assign trip[g] = oc_if.trip;
      odc_ocp_debounce #(
        .MS_CYCLES(MS_CYCLES)
      ) u_deb (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .oc(oc_if.det)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new trip on either driver sets a sticky bit

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      trip_d_r <= 2'h0;
    end else begin
      trip_d_r <= trip;
    end
  end

  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (i_wr && hit(i_addr, odc_pkg::OFF_IRQ_CLR, on_page)) begin
      irq_sts_nxt = irq_sts_r & ~i_wdata;
    end
    // Setting after clearing lets a same-cycle event survive the clear
    irq_sts_nxt = (irq_sts_nxt | {6'h00, trip & ~trip_d_r}) & odc_pkg::MASK_IRQ;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_sts_r <= 8'h00;
    end else begin
      irq_sts_r <= irq_sts_nxt;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_en_r <= 8'h00;
    end else if (i_wr && hit(i_addr, odc_pkg::OFF_IRQ_EN, on_page)) begin
      irq_en_r <= i_wdata & odc_pkg::MASK_IRQ;
    end
  end

  assign o_irq = |(irq_sts_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stands in the cycle after the strobe only

  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      if (hit(i_addr, odc_pkg::OFF_PAGE, 1'b1)) begin
        rdata_nxt = page_r;
      end else if (hit(i_addr, odc_pkg::OFF_PWR, on_page)) begin
        rdata_nxt = pwr_r;
      end else if (hit(i_addr, odc_pkg::OFF_CM, on_page)) begin
        rdata_nxt = cm_r;
      end else if (hit(i_addr, odc_pkg::OFF_OCP, on_page)) begin
        rdata_nxt = ocp_r;
      end else if (hit(i_addr, odc_pkg::OFF_ROUTE, on_page)) begin
        rdata_nxt = route_r;
      end else if (hit(i_addr, odc_pkg::OFF_IRQ_STS, on_page)) begin
        rdata_nxt = irq_sts_r;
      end else if (hit(i_addr, odc_pkg::OFF_IRQ_EN, on_page)) begin
        rdata_nxt = irq_en_r;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls

  always_comb begin
    case (cm_r[odc_pkg::CM_HP_LO +: 2])
      2'b00: hp_cm_nxt = odc_pkg::ODC_CM_CHIP;
      2'b01: hp_cm_nxt = odc_pkg::ODC_CM_1V25;
      2'b10: hp_cm_nxt = odc_pkg::ODC_CM_1V5;
      // 1.65V is out of reach on the low chip common mode
      2'b11: hp_cm_nxt = cm_r[odc_pkg::CM_CHIP] ? odc_pkg::ODC_CM_1V5
                                                 : odc_pkg::ODC_CM_1V65;
      default: hp_cm_nxt = odc_pkg::ODC_CM_CHIP;
    endcase
  end

  // Power-down action only cuts drivers, never the enable bits themselves
  assign hp_cut = ocp_r[odc_pkg::OCP_ACT];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_left_headphone_driver_pwr <= 1'b0;
      o_right_headphone_driver_pwr <= 1'b0;
      o_left_line_driver_pwr <= 1'b0;
      o_right_line_driver_pwr <= 1'b0;
      o_left_mixer_amp_pwr <= 1'b0;
      o_right_mixer_amp_pwr <= 1'b0;
      o_oc_limit <= 2'h0;
    end else begin
      o_left_headphone_driver_pwr <= drv_en[0] && !(trip[0] && hp_cut);
      o_right_headphone_driver_pwr <= drv_en[1] && !(trip[1] && hp_cut);
      o_left_line_driver_pwr <= pwr_r[odc_pkg::PWR_LINE_LEFT];
      o_right_line_driver_pwr <= pwr_r[odc_pkg::PWR_LINE_RIGHT];
      o_left_mixer_amp_pwr <= pwr_r[odc_pkg::PWR_MIX_LEFT];
      o_right_mixer_amp_pwr <= pwr_r[odc_pkg::PWR_MIX_RIGHT];
      o_oc_limit <= trip & {2{!hp_cut}};
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_chip_cm_low <= 1'b0;
      o_hp_cm <= 2'b00;
      o_line_cm_regulator <= 1'b0;
      o_hp_supply_regulator <= 1'b0;
      o_regulator_range_high <= 1'b0;
    end else begin
      o_chip_cm_low <= cm_r[odc_pkg::CM_CHIP];
      o_hp_cm <= hp_cm_nxt;
      o_line_cm_regulator <= cm_r[odc_pkg::CM_LINE];
      o_hp_supply_regulator <= cm_r[odc_pkg::CM_SUPPLY];
      o_regulator_range_high <= cm_r[odc_pkg::CM_SUPPLY] && cm_r[odc_pkg::CM_RANGE];
    end
  end

  // Each source has its own switch, so any mix may be on together
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_route_dac_pos <= 1'b0;
      o_route_left_input_one <= 1'b0;
      o_route_left_mixer_amp <= 1'b0;
      o_route_right_mixer_amp <= 1'b0;
    end else begin
      o_route_dac_pos <= route_r[3];
      o_route_left_input_one <= route_r[2];
      o_route_left_mixer_amp <= route_r[1];
      o_route_right_mixer_amp <= route_r[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_hp_power_off: assert property (@(posedge i_clock) disable iff (i_rst)
    !drv_en[0] |=> !o_left_headphone_driver_pwr)
    else $error("Left headphone powered while disabled");
  chk_line_follow: assert property (@(posedge i_clock) disable iff (i_rst)
    ##1 o_left_line_driver_pwr == $past(pwr_r[odc_pkg::PWR_LINE_LEFT])
        && o_right_line_driver_pwr == $past(pwr_r[odc_pkg::PWR_LINE_RIGHT]))
    else $error("Line driver power mismatch");
  chk_mixer_follow: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(pwr_r[odc_pkg::PWR_MIX_LEFT]) |=> o_left_mixer_amp_pwr)
    else $error("Left mixer amp not powered");
  chk_chip_cm: assert property (@(posedge i_clock) disable iff (i_rst)
    ##1 o_chip_cm_low == $past(cm_r[odc_pkg::CM_CHIP]))
    else $error("Chip common mode mismatch");
  chk_hp_cm_fold: assert property (@(posedge i_clock) disable iff (i_rst)
    (cm_r[6:4] == 3'b111) |=> o_hp_cm == 2'b10)
    else $error("Headphone common mode did not fold to 1.5V");
  chk_hp_cm_high: assert property (@(posedge i_clock) disable iff (i_rst)
    (cm_r[6:4] == 3'b011) |=> o_hp_cm == 2'b11)
    else $error("Headphone common mode not 1.65V");
  chk_line_cm: assert property (@(posedge i_clock) disable iff (i_rst)
    ##1 o_line_cm_regulator == $past(cm_r[odc_pkg::CM_LINE]))
    else $error("Line common mode mismatch");
  chk_hp_supply: assert property (@(posedge i_clock) disable iff (i_rst)
    ##1 o_hp_supply_regulator == $past(cm_r[odc_pkg::CM_SUPPLY]))
    else $error("Headphone supply mismatch");
  chk_range_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    !cm_r[odc_pkg::CM_SUPPLY] |=> !o_regulator_range_high)
    else $error("Range high on analog supply");
  chk_trip_cut: assert property (@(posedge i_clock) disable iff (i_rst)
    (trip[1] && hp_cut) |=> !o_right_headphone_driver_pwr && !o_oc_limit[1])
    else $error("Tripped driver not powered down");
  chk_trip_limit: assert property (@(posedge i_clock) disable iff (i_rst)
    (trip[0] && !hp_cut) |=> o_oc_limit[0])
    else $error("Tripped driver not limited");
  chk_route_mix: assert property (@(posedge i_clock) disable iff (i_rst)
    (route_r[1:0] == 2'b11) |=> o_route_left_mixer_amp && o_route_right_mixer_amp)
    else $error("Mixer routes not both on");
  chk_reserved_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (pwr_r & ~odc_pkg::MASK_PWR) == 8'h00 && (ocp_r & ~odc_pkg::MASK_OCP) == 8'h00)
    else $error("Reserved bit stored");
  chk_irq_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
    (trip[0] && !trip_d_r[0]) |=> irq_sts_r[0])
    else $error("Trip event lost");
  chk_read_latency: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("Read data outside read slot");

endmodule // odc_regs

/* File: tb/odc_regs_tb_top.sv */
// Self-checking bench for the output driver configuration register bank.
// Assumes odc_pkg is compiled first; drives the strobe port and sense inputs.
`timescale 1ns/1ps
module odc_regs_tb_top;
  // Short millisecond keeps the 512 ms debounce within a short run
  localparam int MSC = 10;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_oc_left = 1'b0;
  logic i_oc_right = 1'b0;
  logic [7:0] o_rdata;
  logic hp_l, hp_r, ln_l, ln_r, mx_l, mx_r, chip_low, line_reg, sup_reg, rng_high;
  logic [1:0] hp_cm;
  logic [1:0] oc_limit;
  logic r_dac, r_in1, r_ml, r_mr, o_irq;
  int err_total = 0;
  int checks = 0;

  odc_regs #(.MS_CYCLES(MSC)) odc_regs_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_oc_left(i_oc_left), .i_oc_right(i_oc_right),
    .o_left_headphone_driver_pwr(hp_l), .o_right_headphone_driver_pwr(hp_r),
    .o_left_line_driver_pwr(ln_l), .o_right_line_driver_pwr(ln_r),
    .o_left_mixer_amp_pwr(mx_l), .o_right_mixer_amp_pwr(mx_r),
    .o_chip_cm_low(chip_low), .o_hp_cm(hp_cm), .o_line_cm_regulator(line_reg),
    .o_hp_supply_regulator(sup_reg), .o_regulator_range_high(rng_high),
    .o_oc_limit(oc_limit), .o_route_dac_pos(r_dac), .o_route_left_input_one(r_in1),
    .o_route_left_mixer_amp(r_ml), .o_route_right_mixer_amp(r_mr), .o_irq(o_irq)
  );

  initial begin
    forever #50 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // Read data is looked at only in the one cycle where it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, what);
  endtask

  task automatic settle;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  task automatic oc(input logic l, input logic r);
    @(posedge i_clock);
    i_oc_left <= l;
    i_oc_right <= r;
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #9_000_000;
    err_total++;
    stop_test();
  end

  initial begin
    logic [7:0] cm;
    logic [1:0] hpx;
    int n;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(odc_pkg::OFF_PWR, 8'h00, "page 0 read");
    rd(odc_pkg::OFF_PAGE, 8'h00, "page reset");
    wr(odc_pkg::OFF_PAGE, 8'h01);
    rd(odc_pkg::OFF_PAGE, 8'h01, "page");
    rd(odc_pkg::OFF_PWR, 8'h00, "power reset");
    rd(odc_pkg::OFF_CM, 8'h00, "cm reset");
    rd(odc_pkg::OFF_OCP, 8'h10, "ocp reset");
    rd(odc_pkg::OFF_ROUTE, 8'h00, "route reset");
    // Software keeps every reserved bit at zero; all writable bits set
    wr(odc_pkg::OFF_PWR, 8'h3f);
    rd(odc_pkg::OFF_PWR, 8'h3f, "power mask");
    wr(odc_pkg::OFF_CM, 8'h7b);
    rd(odc_pkg::OFF_CM, 8'h7b, "cm mask");
    wr(odc_pkg::OFF_OCP, 8'h1f);
    rd(odc_pkg::OFF_OCP, 8'h1f, "ocp mask");
    wr(odc_pkg::OFF_ROUTE, 8'h0f);
    rd(odc_pkg::OFF_ROUTE, 8'h0f, "route mask");
    wr(8'h0d, 8'h1f);
    rd(8'h0d, 8'h00, "unmapped");
    for (int i = 0; i < 6; i++) begin
      wr(odc_pkg::OFF_PWR, 8'h01 << i);
      settle();
      chk({2'b00, hp_l, hp_r, ln_l, ln_r, mx_l, mx_r},
          8'h01 << i, "power");
    end
    for (int v = 0; v < 64; v++) begin
      cm = {1'b0, v[5:2], 1'b0, v[1:0]};
      hpx = (v[4:3] == 2'b11 && v[5]) ? 2'b10 : v[4:3];
      wr(odc_pkg::OFF_CM, cm);
      settle();
      chk({chip_low, hp_cm, line_reg, sup_reg, rng_high},
          {v[5], hpx, v[2], v[1], v[1] & v[0]}, "cm");
    end
    for (int v = 0; v < 16; v++) begin
      wr(odc_pkg::OFF_ROUTE, v[7:0]);
      settle();
      chk({r_dac, r_in1, r_ml, r_mr}, v[7:0], "route");
    end
    wr(odc_pkg::OFF_PWR, 8'h30);
    wr(odc_pkg::OFF_IRQ_EN, 8'h03);
    wr(odc_pkg::OFF_OCP, 8'h10);
    oc(1'b1, 1'b0);
    repeat (4) @(posedge i_clock);
    #1;
    chk({oc_limit, o_irq, hp_l}, 8'h07, "limit no debounce");
    rd(odc_pkg::OFF_IRQ_STS, 8'h01, "status left");
    oc(1'b0, 1'b0);
    settle();
    chk(oc_limit, 8'h00, "limit released");
    wr(odc_pkg::OFF_IRQ_EN, 8'h00);
    #1;
    chk(o_irq, 8'h00, "irq masked");
    wr(odc_pkg::OFF_IRQ_CLR, 8'h01);
    rd(odc_pkg::OFF_IRQ_STS, 8'h00, "status cleared");
    wr(odc_pkg::OFF_IRQ_EN, 8'h03);
    // A gap in the condition must restart the period
    wr(odc_pkg::OFF_OCP, 8'h13);
    oc(1'b0, 1'b1);
    repeat (50) @(posedge i_clock);
    oc(1'b0, 1'b0);
    for (int c = 1; c < 8; c++) begin
      wr(odc_pkg::OFF_OCP, 8'(8'h11 | (c << 1)));
      oc(1'b0, 1'b1);
      n = 0;
      while (hp_r === 1'b1 && n < 6000) begin
        @(posedge i_clock);
        #1;
        n++;
      end
      chk(n >= (8 * MSC) << (c - 1) && n <= ((8 * MSC) << (c - 1)) + 5,
          8'h01, "debounce");
      chk({hp_l, hp_r, oc_limit, o_irq}, 8'h11, "power down");
      oc(1'b0, 1'b0);
      wr(odc_pkg::OFF_PWR, 8'h20);
      wr(odc_pkg::OFF_PWR, 8'h30);
      settle();
      chk(hp_r, 8'h01, "restored");
    end
    rd(odc_pkg::OFF_IRQ_STS, 8'h02, "status right");
    wr(odc_pkg::OFF_IRQ_CLR, 8'h03);
    wr(odc_pkg::OFF_OCP, 8'h00);
    oc(1'b1, 1'b1);
    repeat (20) @(posedge i_clock);
    #1;
    chk({oc_limit, hp_l, hp_r, o_irq}, 8'h06, "detection off");
    oc(1'b0, 1'b0);
    // Off our page only the page register answers and takes writes
    wr(odc_pkg::OFF_PAGE, 8'h00);
    wr(odc_pkg::OFF_PWR, 8'h00);
    rd(odc_pkg::OFF_PWR, 8'h00, "page 0 hidden");
    wr(odc_pkg::OFF_PAGE, 8'h01);
    rd(odc_pkg::OFF_PWR, 8'h30, "page 0 write ignored");
    stop_test();
  end
endmodule // odc_regs_tb_top
